// ### hw/adcsp_pkg.sv
// constants shared by the serial conversion port and its result buffer
package adcsp_pkg;

	// ------------------------------------------------------------
	// clock and conversion timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 100;                       // clk_sys rate
	localparam int CONVERT_REQUEST_TYP_NS  = 2750;                      // typical conversion_time
	localparam int CONVERT_REQUEST_MAX_NS  = 3200;                      // longest conversion_time
	// longest time, so round down
	localparam int CONVERT_REQUEST_MAX_CYC = (CONVERT_REQUEST_MAX_NS * CLK_MHZ) / 1000;
	// the block finishes at the typical time, well inside the limit
	localparam int CONVERT_REQUEST_TYP_CYC = (CONVERT_REQUEST_TYP_NS * CLK_MHZ) / 1000;
	localparam int CONVERT_REQUEST_CNT_W   = 9;                         // holds up to CONVERT_REQUEST_MAX_CYC
	localparam logic [CONVERT_REQUEST_CNT_W-1:0] CONVERT_REQUEST_LAST = CONVERT_REQUEST_CNT_W'(CONVERT_REQUEST_TYP_CYC - 1);
	localparam logic [CONVERT_REQUEST_CNT_W-1:0] RST_CONVERT_REQUEST_CNT = 9'h000;

	// ------------------------------------------------------------
	// word sizes and buffer
	// ------------------------------------------------------------
	localparam int RESULT_BITS  = 12;                        // result width, msb first
	localparam int CONFIG_BITS  = 2;                         // configuration word width
	localparam int FIFO_DEPTH   = 32;                        // result buffer depth
	localparam int CFG_SGL_POS  = 1;                         // single_ended_select bit
	localparam int CFG_POL_POS  = 0;                         // channel_polarity_select bit

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [1:0]  RST_CFG     = 2'h2;              // single ended, channel zero
	localparam logic [1:0]  RST_CFG_CNT = 2'h0;
	localparam logic [11:0] RST_RESULT  = 12'h000;
	localparam logic [2:0]  RST_SYNC    = 3'h0;

	// ------------------------------------------------------------
	// multiplexer input codes
	// ------------------------------------------------------------
	localparam logic [1:0]  MUX_CH0     = 2'h0;              // analog_channel_zero
	localparam logic [1:0]  MUX_CH1     = 2'h1;              // analog_channel_one
	localparam logic [1:0]  MUX_GND     = 2'h2;              // ground

endpackage : adcsp_pkg

// ### hw/adcsp_port.sv
// serial conversion port of a sampling converter, with its result buffer
`timescale 1ns/1ps

// ------------------------------------------------------------
// result buffer
// ------------------------------------------------------------
module adcsp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// draining side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];              // storage words
	logic [AW-1:0]    wr_ptr;                   // next slot to write
	logic [AW-1:0]    rd_ptr;                   // oldest word
	logic [AW:0]      count;                    // words held
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// flags are registered so both ready and valid come from flops
	always_comb
	begin
		push        = in_valid & in_ready;
		pop         = out_valid & out_ready;
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count  = count;
		if (push & ~pop)
		begin
			next_count = (AW+1)'(count + 1'b1);
		end
		else if (pop & ~push)
		begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	// pointers, count and flags
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			in_ready  <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end

	// storage has no reset; only written slots are ever read
	always_ff @(posedge clk_sys)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign out_data = mem[rd_ptr];

endmodule : adcsp_fifo

// ------------------------------------------------------------
// conversion port
// ------------------------------------------------------------
// Notes on behaviour
// RULE_01 - rising convert request starts a conversion
// RULE_02 - conversion ends within 3.2 us
// RULE_03 - request still high after conversion: sleep
// RULE_04 - result driver enabled while request is low
// RULE_05 - result pin released after request rises
// RULE_06 - result shifted out paced by shift clock
// RULE_07 - two-channel part takes serial configuration word
// RULE_08 - host allows 12 or 10 clock sampling
// RULE_09 - host holds request high for conversion time
// RULE_10 - host keeps request low 12 clocks
// RULE_11 - data changes on falling, captured rising
// RULE_12 - two config bits after fall, rest ignored
// RULE_13 - zeros follow once result is sent
// RULE_14 - config word selects single-ended or differential inputs
// RULE_15 - result sent most significant bit first
// RULE_16 - host shift clock at most 20 MHz
module adcsp_port #(
	parameter bit TWO_CHANNEL = 1'b1,           // 1: two-channel variant with config input
	parameter int DEPTH       = adcsp_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// serial pins
	input  wire logic        convert_request,
	input  wire logic        shift_clock,
	input  wire logic        serial_config_in,
	output logic             serial_result_out,
	output logic             serial_result_oe_n,
	// converter core results
	input  wire logic [11:0] sample_data,
	input  wire logic        sample_valid,
	output logic             sample_ready,
	// converter core control
	output logic             convert_request_start,
	output logic             converting,
	output logic             sleep_mode,
	output logic [1:0]       mux_plus_sel,
	output logic [1:0]       mux_minus_sel
);
	typedef enum logic [2:0] {
		ST_SAMPLE  = 3'h1,                      // request low, shifting
		ST_CONVERT = 3'h2,                      // timed conversion
		ST_SLEEP   = 3'h4                       // done, request still high
	} adcsp_state_t;

	// decode {single_ended_select, channel_polarity_select} into input pair
	function automatic logic [3:0] adcsp_mux(input logic [1:0] cfg);
		logic sgl;
		logic pol;
		sgl = cfg[adcsp_pkg::CFG_SGL_POS];
		pol = cfg[adcsp_pkg::CFG_POL_POS];
		if (sgl)
		begin
			adcsp_mux = {pol ? adcsp_pkg::MUX_CH1 : adcsp_pkg::MUX_CH0, adcsp_pkg::MUX_GND};
		end
		else
		begin
			adcsp_mux = pol ? {adcsp_pkg::MUX_CH1, adcsp_pkg::MUX_CH0}
			                : {adcsp_pkg::MUX_CH0, adcsp_pkg::MUX_CH1};
		end
	endfunction : adcsp_mux

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] convert_request_sync;                      // three-stage chain, request
	logic [2:0] sck_sync;                       // three-stage chain, shift clock
	logic [2:0] sdi_sync;                       // three-stage chain, config data
	logic       convert_request_lvl;                       // filtered levels
	logic       sck_lvl;
	logic       sdi_lvl;
	logic       next_convert_request_lvl;
	logic       next_sck_lvl;
	logic       next_sdi_lvl;
	logic       convert_request_rise;
	logic       convert_request_fall;
	logic       sck_rise;
	logic       sck_fall;

	// a level moves only when stages two and three agree; stage one feeds stage two only
	always_comb
	begin
		next_convert_request_lvl = (convert_request_sync[1] == convert_request_sync[2]) ? convert_request_sync[2] : convert_request_lvl;
		next_sck_lvl  = (sck_sync[1] == sck_sync[2]) ? sck_sync[2] : sck_lvl;
		next_sdi_lvl  = (sdi_sync[1] == sdi_sync[2]) ? sdi_sync[2] : sdi_lvl;
		convert_request_rise     = next_convert_request_lvl & ~convert_request_lvl;
		convert_request_fall     = ~next_convert_request_lvl & convert_request_lvl;
		sck_rise      = next_sck_lvl & ~sck_lvl;
		sck_fall      = ~next_sck_lvl & sck_lvl;
	end

	// synchroniser flops; 125 ns link clock leaves ample samples per phase
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			convert_request_sync <= adcsp_pkg::RST_SYNC;
			sck_sync  <= adcsp_pkg::RST_SYNC;
			sdi_sync  <= adcsp_pkg::RST_SYNC;
			convert_request_lvl  <= 1'b0;
			sck_lvl   <= 1'b0;
			sdi_lvl   <= 1'b0;
		end
		else
		begin
			convert_request_sync <= {convert_request_sync[1:0], convert_request};
			sck_sync  <= {sck_sync[1:0], shift_clock};
			sdi_sync  <= {sdi_sync[1:0], serial_config_in};
			convert_request_lvl  <= next_convert_request_lvl;
			sck_lvl   <= next_sck_lvl;
			sdi_lvl   <= next_sdi_lvl;
		end
	end

	// ------------------------------------------------------------
	// result buffer between core and serial port
	// ------------------------------------------------------------
	logic [11:0] head_data;                     // oldest buffered result
	logic        head_valid;
	logic        head_pop;                      // taken at end of conversion

	adcsp_fifo #(
		.WIDTH (adcsp_pkg::RESULT_BITS),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_data   (sample_data),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.out_data  (head_data),
		.out_valid (head_valid),
		.out_ready (head_pop)
	);

	// ------------------------------------------------------------
	// conversion sequencer and shifter
	// ------------------------------------------------------------
	adcsp_state_t                       state;
	adcsp_state_t                       next_state;
	logic [adcsp_pkg::CONVERT_REQUEST_CNT_W-1:0]   convert_request_cnt;        // cycles into conversion
	logic [adcsp_pkg::CONVERT_REQUEST_CNT_W-1:0]   next_convert_request_cnt;
	logic [11:0]                        result;          // last finished result
	logic [11:0]                        next_result;
	logic [11:0]                        shreg;           // outgoing bits, msb on the pin
	logic [11:0]                        next_shreg;
	logic [1:0]                         cfg;             // captured configuration word
	logic [1:0]                         next_cfg;
	logic [1:0]                         cfg_cnt;         // config bits taken this cycle
	logic [1:0]                         next_cfg_cnt;
	logic [3:0]                         mux_pair;
	logic                               next_oe_n;
	logic                               next_start;

	// next-state and datapath
	always_comb
	begin
		next_state    = state;
		next_convert_request_cnt = convert_request_cnt;
		next_result   = result;
		next_shreg    = shreg;
		next_cfg      = cfg;
		next_cfg_cnt  = cfg_cnt;
		next_oe_n     = serial_result_oe_n;
		next_start    = 1'b0;
		head_pop      = 1'b0;
		unique case (state)
			ST_SAMPLE:
			begin
				if (convert_request_rise)
				begin
					// start converting and let go of the pin
					next_state    = ST_CONVERT;                              // see RULE_01
					next_start    = 1'b1;
					next_convert_request_cnt = adcsp_pkg::RST_CONVERT_REQUEST_CNT;
					next_oe_n     = 1'b1;                                    // see RULE_05
				end
				else
				begin
					next_oe_n = 1'b0;                                        // see RULE_04
					// falling shift clock moves the next bit out, zeros behind it
					if (sck_fall)
					begin
						next_shreg = {shreg[10:0], 1'b0};                    // see RULE_06, RULE_11, RULE_13
					end
					// only the first two rising edges carry configuration
					if (TWO_CHANNEL && sck_rise && cfg_cnt != 2'(adcsp_pkg::CONFIG_BITS))
					begin
						next_cfg     = {cfg[0], sdi_lvl};                    // see RULE_07, RULE_12
						next_cfg_cnt = 2'(cfg_cnt + 1'b1);
					end
				end
			end
			ST_CONVERT:
			begin
				if (convert_request_fall)
				begin
					// request dropped early: serve the previous result
					next_state = ST_SAMPLE;
					next_shreg = result;
					next_oe_n  = 1'b0;
					next_cfg_cnt = adcsp_pkg::RST_CFG_CNT;
				end
				else if (convert_request_cnt == adcsp_pkg::CONVERT_REQUEST_LAST)
				begin
					// finished at the typical time; an empty buffer yields zero
					next_state  = ST_SLEEP;                                  // see RULE_02, RULE_03
					head_pop    = head_valid;
					next_result = head_valid ? head_data : adcsp_pkg::RST_RESULT;
				end
				else
				begin
					next_convert_request_cnt = adcsp_pkg::CONVERT_REQUEST_CNT_W'(convert_request_cnt + 1'b1);
				end
			end
			ST_SLEEP:
			begin
				if (convert_request_fall)
				begin
					// wake, drive the pin with the msb already in place
					next_state   = ST_SAMPLE;
					next_shreg   = result;                                   // see RULE_15
					next_oe_n    = 1'b0;                                     // see RULE_04
					next_cfg_cnt = adcsp_pkg::RST_CFG_CNT;
				end
			end
		endcase
	end

	// sequencer registers; the pin starts released as if request were high
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state              <= ST_SLEEP;
			convert_request_cnt           <= adcsp_pkg::RST_CONVERT_REQUEST_CNT;
			result             <= adcsp_pkg::RST_RESULT;
			shreg              <= adcsp_pkg::RST_RESULT;
			cfg                <= adcsp_pkg::RST_CFG;
			cfg_cnt            <= adcsp_pkg::RST_CFG_CNT;
			serial_result_oe_n <= 1'b1;
			convert_request_start         <= 1'b0;
		end
		else
		begin
			state              <= next_state;
			convert_request_cnt           <= next_convert_request_cnt;
			result             <= next_result;
			shreg              <= next_shreg;
			cfg                <= next_cfg;
			cfg_cnt            <= next_cfg_cnt;
			serial_result_oe_n <= next_oe_n;
			convert_request_start         <= next_start;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_comb
	begin
		// single-channel part measures its fixed pair
		mux_pair = TWO_CHANNEL ? adcsp_mux(next_cfg) : {adcsp_pkg::MUX_CH0, adcsp_pkg::MUX_CH1};  // see RULE_14
	end

	// status and multiplexer lines, one flop each
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serial_result_out <= 1'b0;
			converting        <= 1'b0;
			sleep_mode        <= 1'b1;
			mux_plus_sel      <= adcsp_pkg::MUX_CH0;
			// one-channel part resets to its fixed pair, so its mux never moves
			mux_minus_sel     <= TWO_CHANNEL ? adcsp_pkg::MUX_GND : adcsp_pkg::MUX_CH1;
		end
		else
		begin
			serial_result_out <= next_shreg[11];                             // see RULE_15
			converting        <= next_state == ST_CONVERT;
			sleep_mode        <= next_state == ST_SLEEP;                     // see RULE_03
			mux_plus_sel      <= mux_pair[3:2];
			mux_minus_sel     <= mux_pair[1:0];
		end
	end

endmodule : adcsp_port

// ### verif/adcsp_port_sva.sv
// concurrent checks on the pins of the serial conversion port
`timescale 1ns/1ps
module adcsp_port_sva (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// serial pins
	input wire logic       convert_request,
	input wire logic       shift_clock,
	input wire logic       serial_result_out,
	input wire logic       serial_result_oe_n,
	// core side
	input wire logic       sample_valid,
	input wire logic       sample_ready,
	input wire logic       convert_request_start,
	input wire logic       converting,
	input wire logic       sleep_mode,
	input wire logic [1:0] mux_plus_sel,
	input wire logic [1:0] mux_minus_sel
);
	// ------------------------------------------------------------
	// checks; pin edges take three sync stages, hence the ranges
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	a_start_cause: assert property ($rose(convert_request) && !serial_result_oe_n |-> ##[2:5] convert_request_start)
		else $error("no conversion start after request rise");
	a_start_pulse: assert property (convert_request_start |=> !convert_request_start && converting)
		else $error("start pulse too long or conversion missing");
	a_convert_request_time: assert property ($rose(converting) |-> ##274 (converting || !convert_request) ##1 !converting)
		else $error("conversion length wrong");
	a_sleep_hold: assert property (sleep_mode && convert_request |=> sleep_mode)
		else $error("sleep left while request high");
	a_drive_on_low: assert property ($fell(convert_request) |-> ##[2:5] !serial_result_oe_n)
		else $error("result driver not enabled");
	a_hiz_on_req: assert property ($rose(convert_request) |-> ##[2:5] serial_result_oe_n)
		else $error("result driver not released");
	a_hiz_hold: assert property (convert_request && serial_result_oe_n |=> serial_result_oe_n)
		else $error("driver enabled while request high");
	a_bit_on_fall: assert property (!serial_result_oe_n && $changed(serial_result_out) |-> !shift_clock)
		else $error("result bit changed while shift clock high");
	a_mux_quiet: assert property ($changed(mux_plus_sel) || $changed(mux_minus_sel) |-> !convert_request && !converting)
		else $error("mux changed outside a transfer");
	a_mux_legal: assert property (mux_plus_sel != adcsp_pkg::MUX_GND && mux_minus_sel != mux_plus_sel
		&& mux_minus_sel != 2'h3)
		else $error("illegal mux selection");
	a_ready_full: assert property ($fell(sample_ready) |-> $past(sample_valid) || $past(sample_valid, 2))
		else $error("buffer went full without a push");
	// main scenarios reached
	cover property ($rose(converting));
	cover property ($fell(serial_result_oe_n));
	cover property ($fell(sample_ready));
endmodule : adcsp_port_sva

bind adcsp_port adcsp_port_sva chk (.clk_sys(clk_sys), .rst_n(rst_n), .convert_request(convert_request),
	.shift_clock(shift_clock), .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
	.sample_valid(sample_valid), .sample_ready(sample_ready), .convert_request_start(convert_request_start), .converting(converting),
	.sleep_mode(sleep_mode), .mux_plus_sel(mux_plus_sel), .mux_minus_sel(mux_minus_sel));

// ### verif/adcsp_host.sv
// serial host model that drives the conversion port's pins
`timescale 1ns/1ps
module adcsp_host (
	// pins toward the port
	output logic      convert_request,
	output logic      shift_clock,
	output logic      serial_config_in,
	input  wire logic serial_result_pin
);
	// request high from time zero, so the port starts out asleep
	initial
	begin
		convert_request  = 1'b1;
		shift_clock      = 1'b0;
		serial_config_in = 1'b0;
	end
	// start a conversion and wait past its longest time
	task automatic convert();
		convert_request = 1'b1;
		#3500;
	endtask : convert
	// one transfer of 14 shift clocks at 125 ns; clock stands low outside
	// shift clock and config edges sit an eighth clock off the system grid, never on a clk_sys edge; request falls on a falling one
	task automatic frame(input logic [1:0] cfg, output logic [13:0] got);
		logic last;
		got = 14'h0000;
		last = 1'b0;
		convert_request = 1'b0;
		#201.25;
		for (int i = 0; i < 14; i++)
		begin
			// config msb first, then a changing pattern the port must ignore
			last = (i < 2) ? cfg[1 - i] : ~last;
			serial_config_in = last;
			#62.5;
			got = {got[12:0], serial_result_pin};
			shift_clock = 1'b1;
			#62.5;
			shift_clock = 1'b0;
		end
		// ends back on a falling clk_sys edge, ready for the next call
		#98.75;
	endtask : frame
endmodule : adcsp_host

// ### verif/adc_serial_conversion_port_test.sv
// self-checking bench of the conversion port against a host model
`timescale 1ns/1ps
module adc_serial_conversion_port_test;
	// a table row: config word, buffered word, expected mux codes
	typedef struct packed {
		logic [1:0]  cfg;
		logic [11:0] word;
		logic [1:0]  plus;
		logic [1:0]  minus;
	} adcsp_row_t;
	logic        clk_sys, rst_n, sample_valid; // clock, reset, core valid
	logic [11:0] sample_data;                  // core word
	logic [13:0] got;                          // bits seen by the host
	wire  logic  convert_request, shift_clock, serial_config_in, serial_result_pin;
	logic        serial_result_out, serial_result_oe_n, sample_ready, convert_request_start, converting, sleep_mode;
	logic [1:0]  mux_plus_sel, mux_minus_sel;   // mux codes
	logic [1:0]  single_plus, single_minus;     // mux codes of the one-channel part
	int          n_errors, check_count, n_push;
	adcsp_row_t  rows [4];
	// released pin shows the inverse, so a late enable cannot pass unseen
	assign serial_result_pin = serial_result_oe_n ? ~serial_result_out : serial_result_out;
	adcsp_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .convert_request(convert_request),
		.shift_clock(shift_clock), .serial_config_in(serial_config_in), .serial_result_out(serial_result_out),
		.serial_result_oe_n(serial_result_oe_n), .sample_data(sample_data), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .convert_request_start(convert_request_start), .converting(converting), .sleep_mode(sleep_mode),
		.mux_plus_sel(mux_plus_sel), .mux_minus_sel(mux_minus_sel));
	adcsp_host host (.convert_request(convert_request), .shift_clock(shift_clock),
		.serial_config_in(serial_config_in), .serial_result_pin(serial_result_pin));
	// one-channel variant on the same pins; only its fixed mux pair is watched
	adcsp_port #(.TWO_CHANNEL(1'b0)) dut_single (.clk_sys(clk_sys), .rst_n(rst_n),
		.convert_request(convert_request), .shift_clock(shift_clock), .serial_config_in(serial_config_in),
		.serial_result_out(), .serial_result_oe_n(), .sample_data(sample_data), .sample_valid(sample_valid),
		.sample_ready(), .convert_request_start(), .converting(), .sleep_mode(),
		.mux_plus_sel(single_plus), .mux_minus_sel(single_minus));
	always #5 clk_sys = ~clk_sys;
	// ------------------------------------------------------------
	// compare, stimulus and closing tasks
	// ------------------------------------------------------------
	task automatic chk_bit(input string what, input logic exp, input logic seen);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, seen);
		end
	endtask : chk_bit
	task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk_vec
	// hand one word to the buffer at the falling edge
	task automatic push(input logic [11:0] word);
		@(negedge clk_sys);
		sample_data = word;
		sample_valid = 1'b1;
		@(negedge clk_sys);
		sample_valid = 1'b0;
	endtask : push
	// one transfer: result msb first, then zeros for the spare clocks
	task automatic transfer(input logic [1:0] cfg, input logic [11:0] exp);
		host.frame(cfg, got);
		chk_vec("result", 16'(exp), 16'(got[13:2]));
		chk_vec("tail", 16'h0000, 16'(got[1:0]));
		chk_bit("oe_n low", 1'b0, serial_result_oe_n);
	endtask : transfer
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if ((n_errors == 0) && (check_count > 0))
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// watchdog: about 40 cycles of 5.6 us are expected
	initial
	begin
		#400000;
		n_errors++;
		$display("MISMATCH watchdog expected finish seen hang");
		close_out();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		sample_valid = 1'b0;
		sample_data = 12'h000;
		n_errors = 0;
		check_count = 0;
		n_push = 0;
		rows[0] = '{2'h2, 12'ha5c, adcsp_pkg::MUX_CH0, adcsp_pkg::MUX_GND};
		rows[1] = '{2'h3, 12'h5a3, adcsp_pkg::MUX_CH1, adcsp_pkg::MUX_GND};
		rows[2] = '{2'h0, 12'hfff, adcsp_pkg::MUX_CH0, adcsp_pkg::MUX_CH1};
		rows[3] = '{2'h1, 12'h801, adcsp_pkg::MUX_CH1, adcsp_pkg::MUX_CH0};
		repeat (16) @(negedge clk_sys);
		chk_bit("reset oe_n", 1'b1, serial_result_oe_n);
		chk_bit("reset sleep", 1'b1, sleep_mode);
		chk_bit("reset ready", 1'b1, sample_ready);
		chk_vec("reset single minus", 16'(adcsp_pkg::MUX_CH1), 16'(single_minus));
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		// asleep from reset: first transfer gives zeros
		transfer(2'h2, 12'h000);
		// every config code, each with its own word
		foreach (rows[i])
		begin
			push(rows[i].word);
			host.convert();
			chk_bit("hiz", 1'b1, serial_result_oe_n);
			transfer(rows[i].cfg, rows[i].word);
			chk_vec("plus", 16'(rows[i].plus), 16'(mux_plus_sel));
			chk_vec("minus", 16'(rows[i].minus), 16'(mux_minus_sel));
			chk_vec("single plus", 16'(adcsp_pkg::MUX_CH0), 16'(single_plus));
			chk_vec("single minus", 16'(adcsp_pkg::MUX_CH1), 16'(single_minus));
		end
		// fill the buffer until it refuses
		while (sample_ready === 1'b1 && n_push < 40)
		begin
			push(12'h100 + 12'(n_push));
			n_push++;
		end
		chk_vec("fill count", 16'd32, 16'(n_push));
		// timed conversion pops the oldest word
		fork
			host.convert();
			begin
				@(posedge convert_request_start);
				repeat (270) @(negedge clk_sys);
				chk_bit("busy", 1'b1, converting);
				repeat (10) @(negedge clk_sys);
				chk_bit("done", 1'b0, converting);
				chk_bit("asleep", 1'b1, sleep_mode);
			end
		join
		transfer(2'h2, 12'h100);
		// drain the rest in order, then an empty buffer gives zeros
		for (int i = 1; i <= 32; i++)
		begin
			host.convert();
			transfer(2'(i), (i < 32) ? 12'h100 + 12'(i) : 12'h000);
		end
		// request dropped mid-conversion: previous result again, buffer untouched
		push(12'h3c3);
		host.convert_request = 1'b1;
		#1000;
		chk_bit("abort busy", 1'b1, converting);
		transfer(2'h2, 12'h000);
		host.convert();
		transfer(2'h2, 12'h3c3);
		close_out();
	end
endmodule : adc_serial_conversion_port_test
